/* File: design/astcs_device.sv */
/*
  astcs_device: sample timing, power-down and colour multiplexer control.
  assumes: mclk_en marks one master clock rising edge per pulse; pins
  pixel_sync and autocycle_pulse_pin come from outside and are synchronised.
*/
module astcs_device
  import astcs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  astcs_link_if.dev link,
  output logic o_sample,
  output logic [2:0] o_sample_inputs,
  output logic [3:0] o_block_en,
  output logic [2:0] o_chan_en,
  output logic o_mono,
  output logic o_cds,
  output logic o_max_speed,
  output logic [1:0] o_input_sel,
  output logic [1:0] o_coef_sel,
  output logic [7:0] o_setup3
);
  import astcs_pkg::*;

  typedef struct packed {
    logic [7:0] setup1;
    logic [7:0] setup3;
    logic [7:0] setup4;
    logic [7:0] setup5;
    logic [7:0] setup6;
    logic [1:0] ps_sync;
    logic [1:0] ac_sync;
    logic ps_prev;
    logic ac_prev;
    logic int_pulse;
    logic [2:0] dly_cnt;
    logic dly_busy;
    logic [1:0] cycle_col;
    logic sample;
    logic [2:0] sample_inputs;
  } astcs_dev_state_t;

  astcs_dev_state_t st_r;
  astcs_dev_state_t st_nxt;

  function automatic logic [2:0] one_hot_col(input logic [1:0] c);
    one_hot_col = (c == 2'(COL_GREEN)) ? 3'h2 : (c == 2'(COL_BLUE)) ? 3'h4 : 3'h1;
  endfunction

  function automatic logic [1:0] next_col(input logic [1:0] c);
    unique case (c)
      2'(COL_RED): next_col = 2'(COL_GREEN);
      2'(COL_GREEN): next_col = 2'(COL_BLUE);
      default: next_col = 2'(COL_RED);
    endcase
  endfunction

  logic line_mode;
  logic acyc_sel;
  logic force_mux;
  logic mono_eff;
  logic power_any;
  logic ps_now;
  logic sync_edge;
  logic ext_fall;
  logic sync_src;
  logic ac_rise;

  always_comb begin
    line_mode = st_r.setup4[S4_LINE];
    acyc_sel = st_r.setup4[S4_ACYC];
    force_mux = st_r.setup4[S4_FORCE];
    mono_eff = st_r.setup1[S1_MONO] | line_mode;
    ps_now = st_r.ps_sync[1];
    // edge chosen by edge_polarity_select: 1 rising, 0 falling
    sync_edge = st_r.setup5[S5_POS] ? (ps_now & ~st_r.ps_prev)
                                    : (~ps_now & st_r.ps_prev);
    ext_fall = st_r.ps_prev & ~ps_now;
    // internal pulse replaces the pin pulse when detection is on
    sync_src = st_r.setup5[S5_DET] ? (st_r.int_pulse & link.mclk_en) : ext_fall;
    ac_rise = st_r.ac_sync[1] & ~st_r.ac_prev;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.sample = 1'b0;
    // only the second stage of each synchroniser is read by logic
    st_nxt.ps_sync = {st_r.ps_sync[0], link.pixel_sync};
    st_nxt.ac_sync = {st_r.ac_sync[0], link.autocycle_pulse_pin};
    // config port stays live in every power-down state
    if (link.cfg_wr) begin
      unique case (link.cfg_addr)
        A_SETUP1: st_nxt.setup1 = link.cfg_data;
        A_SETUP3: st_nxt.setup3 = link.cfg_data;
        A_SETUP4: st_nxt.setup4 = link.cfg_data;
        A_SETUP5: st_nxt.setup5 = {3'h0, link.cfg_data[4:0]};
        A_SETUP6: st_nxt.setup6 = {4'h0, link.cfg_data[3:0]};
        A_ACYC_RST: st_nxt.cycle_col = 2'(COL_RED);
        default: st_nxt = st_nxt;
      endcase
    end
    if (link.mclk_en) begin
      st_nxt.ps_prev = ps_now;
      st_nxt.ac_prev = st_r.ac_sync[1];
      // internal pulse lasts one mclk period
      if (st_r.int_pulse) begin
        st_nxt.int_pulse = 1'b0;
      end
      if (st_r.dly_busy) begin
        if (st_r.dly_cnt == 3'h1) begin
          st_nxt.dly_busy = 1'b0;
          st_nxt.int_pulse = 1'b1;
        end
        st_nxt.dly_cnt = st_r.dly_cnt - 3'h1;
      end
      if (st_r.setup5[S5_DET] && sync_edge) begin
        // zero delay: the pulse starts at the detecting edge
        if (st_r.setup5[S5_DEL +: 3] == 3'h0) begin
          st_nxt.int_pulse = 1'b1;
        end else begin
          st_nxt.dly_cnt = st_r.setup5[S5_DEL +: 3];
          st_nxt.dly_busy = 1'b1;
        end
      end
      // sample on this mclk edge, the first after the pulse ended
      if (sync_src && power_any) begin
        st_nxt.sample = 1'b1;
        if (!mono_eff) begin
          st_nxt.sample_inputs = 3'h7;
        end else if (line_mode) begin
          st_nxt.sample_inputs = one_hot_col(o_input_sel);
        end else begin
          st_nxt.sample_inputs = one_hot_col(st_r.setup3[S3_INSEL +: 2]);
        end
      end
      // advance once per high pulse, in fixed colour order
      if (line_mode && acyc_sel && ac_rise) begin
        st_nxt.cycle_col = next_col(st_r.cycle_col);
      end
    end
    if (!st_r.setup5[S5_DET]) begin
      st_nxt.int_pulse = 1'b0;
      st_nxt.dly_busy = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_r <= '0;
      st_r.setup1 <= SETUP1_RST;
      st_r.setup3 <= SETUP3_RST;
      st_r.setup4 <= SETUP4_RST;
      st_r.setup5 <= SETUP5_RST;
      st_r.setup6 <= SETUP6_RST;
      st_r.cycle_col <= 2'(COL_RED);
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    // selective mode ignores the global enable
    if (st_r.setup1[S1_SELPWR]) begin
      o_block_en = ~st_r.setup6[3:0];
    end else begin
      o_block_en = {4{st_r.setup1[S1_EN]}};
    end
    power_any = |o_block_en;
    o_chan_en[0] = power_any;
    o_chan_en[1] = power_any & ~line_mode;
    o_chan_en[2] = power_any & ~line_mode;
    // source selection: force_mux_enable, autocycle_select
    unique case ({force_mux, acyc_sel})
      2'b00: begin
        o_input_sel = st_r.setup4[S4_INTSEL +: 2];
        o_coef_sel = st_r.setup4[S4_INTSEL +: 2];
      end
      2'b01: begin
        o_input_sel = st_r.cycle_col;
        o_coef_sel = st_r.cycle_col;
      end
      2'b10: begin
        o_input_sel = st_r.setup4[S4_FORCESEL +: 2];
        o_coef_sel = st_r.setup4[S4_INTSEL +: 2];
      end
      2'b11: begin
        o_input_sel = st_r.setup4[S4_FORCESEL +: 2];
        o_coef_sel = st_r.cycle_col;
      end
    endcase
    if (!line_mode) begin
      o_input_sel = st_r.setup3[S3_INSEL +: 2];
      o_coef_sel = st_r.setup3[S3_INSEL +: 2];
    end
  end

  assign o_sample = st_r.sample;
  assign o_sample_inputs = st_r.sample_inputs;
  assign o_mono = mono_eff;
  assign o_cds = st_r.setup1[S1_CDS];
  assign o_max_speed = st_r.setup1[S1_MAXSPD];
  assign o_setup3 = st_r.setup3;
  assign link.sample = st_r.sample;
endmodule

/* File: design/astcs_pkg.sv */
/*
  astcs_pkg: shared constants and types for the sample timing and
  colour select block and its timing controller.
  assumes: one system clock of CLK_HZ; both ends import this package.
*/
package astcs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MCLK_MAX_HZ = 12_000_000;
  localparam int unsigned SYNC_MAX_HZ = 6_000_000;
  localparam logic [7:0] MCLK_DIV_MIN = 8'((CLK_HZ + MCLK_MAX_HZ - 1) / MCLK_MAX_HZ);
  localparam logic [7:0] MCLK_DIV_RST = MCLK_DIV_MIN;

  // device configuration addresses and reset values
  localparam logic [5:0] A_SETUP1 = 6'h01;
  localparam logic [5:0] A_SETUP3 = 6'h03;
  localparam logic [5:0] A_ACYC_RST = 6'h05;
  localparam logic [5:0] A_SETUP4 = 6'h06;
  localparam logic [5:0] A_SETUP5 = 6'h08;
  localparam logic [5:0] A_SETUP6 = 6'h09;
  localparam logic [7:0] SETUP1_RST = 8'h03;
  localparam logic [7:0] SETUP3_RST = 8'h1F;
  localparam logic [7:0] SETUP4_RST = 8'h00;
  localparam logic [7:0] SETUP5_RST = 8'h00;
  localparam logic [7:0] SETUP6_RST = 8'h00;

  // field positions
  localparam int S1_EN = 0;
  localparam int S1_CDS = 1;
  localparam int S1_MONO = 2;
  localparam int S1_SELPWR = 3;
  localparam int S1_MAXSPD = 6;
  localparam int S3_INSEL = 6;
  localparam int S3_CDSREF = 4;
  localparam int S4_LINE = 0;
  localparam int S4_ACYC = 1;
  localparam int S4_FORCE = 2;
  localparam int S4_INTSEL = 4;
  localparam int S4_FORCESEL = 6;
  localparam int S5_DET = 0;
  localparam int S5_DEL = 1;
  localparam int S5_POS = 4;

  // setup register 1 values per mode
  localparam logic [7:0] S1_M1_CDS = 8'h03;
  localparam logic [7:0] S1_M1_NOCDS = 8'h01;
  localparam logic [7:0] S1_M2_CDS = 8'h07;
  localparam logic [7:0] S1_M2_NOCDS = 8'h05;
  localparam logic [7:0] S1_M4 = 8'h45;

  // mclk to sync ratios
  localparam logic [7:0] RATIO_M12 = 8'h06;
  localparam logic [7:0] RATIO_M3 = 8'h03;
  localparam logic [7:0] RATIO_M4 = 8'h02;
  localparam logic [6:0] SLOW_N_MIN = 7'h04;

  // controller APB map (byte addresses)
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_DIV = 8'h04;
  localparam logic [7:0] R_MODE = 8'h08;
  localparam logic [7:0] R_CFG = 8'h0C;
  localparam logic [7:0] R_ACYC = 8'h10;
  localparam logic [7:0] R_STAT = 8'h14;

  typedef enum logic [1:0] {
    COL_RED = 2'h0,
    COL_GREEN = 2'h1,
    COL_BLUE = 2'h2
  } astcs_colour_t;
endpackage

/* File: design/astcs_link_if.sv */
/*
  astcs_link_if: wires between the timing controller and the device.
  assumes: every signal is a plain level on i_clk_sys; no clocking block.
*/
interface astcs_link_if;
  logic mclk_en;
  logic pixel_sync;
  logic autocycle_pulse_pin;
  logic cfg_wr;
  logic [5:0] cfg_addr;
  logic [7:0] cfg_data;
  logic sample;
  modport dev (input mclk_en, pixel_sync, autocycle_pulse_pin, cfg_wr, cfg_addr, cfg_data,
    output sample);
  modport ctl (output mclk_en, pixel_sync, autocycle_pulse_pin, cfg_wr, cfg_addr, cfg_data,
    input sample);
endinterface

/* File: design/astcs_ctrl.sv */
/*
  astcs_ctrl: scanner timing controller; makes master clock enable,
  pixel_sync, cycle pulses and device config writes from APB registers.
  assumes: zero-wait APB slave on i_clk_sys; device on the link.
*/
module astcs_ctrl
  import astcs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  astcs_link_if.ctl link
);
  import astcs_pkg::*;

  typedef struct packed {
    logic run;
    logic [7:0] div;
    logic [2:0] mode;
    logic cds;
    logic [6:0] slow_n;
    logic [7:0] s3_base;
    logic [7:0] div_cnt;
    logic [7:0] ratio_cnt;
    logic sync;
    logic acyc_req;
    logic acyc;
    logic cfg_wr;
    logic [5:0] cfg_addr;
    logic [7:0] cfg_data;
    logic s3_pend;
    logic [15:0] samples;
  } astcs_ctl_state_t;

  astcs_ctl_state_t st_r;
  astcs_ctl_state_t st_nxt;

  function automatic logic [7:0] ratio_of(input logic [2:0] m, input logic [6:0] n);
    unique case (m)
      3'h1, 3'h2: ratio_of = RATIO_M12;
      3'h3: ratio_of = RATIO_M3;
      3'h4: ratio_of = RATIO_M4;
      default: ratio_of = {(n < SLOW_N_MIN) ? SLOW_N_MIN : n, 1'b0};
    endcase
  endfunction

  function automatic logic [7:0] setup1_of(input logic [2:0] m, input logic c);
    unique case (m)
      3'h2, 3'h3, 3'h6: setup1_of = c ? S1_M2_CDS : S1_M2_NOCDS;
      3'h4: setup1_of = S1_M4; // no double sampling in mode 4
      default: setup1_of = c ? S1_M1_CDS : S1_M1_NOCDS;
    endcase
  endfunction

  logic wr_acc;
  logic tick;
  logic mapped;

  always_comb begin
    wr_acc = i_psel & i_penable & i_pwrite;
    tick = st_r.run && (st_r.div_cnt == 8'h0);
    mapped = (i_paddr <= R_STAT) && (i_paddr[1:0] == 2'b00);
    st_nxt = st_r;
    st_nxt.cfg_wr = 1'b0;
    if (st_r.run) begin
      st_nxt.div_cnt = tick ? st_r.div - 8'h1 : st_r.div_cnt - 8'h1;
    end else begin
      st_nxt.div_cnt = 8'h0;
    end
    if (tick) begin
      // sync high for exactly one mclk period per sample
      st_nxt.sync = (st_r.ratio_cnt == 8'h0);
      st_nxt.ratio_cnt = (st_r.ratio_cnt == 8'h0)
                         ? ratio_of(st_r.mode, st_r.slow_n) - 8'h1
                         : st_r.ratio_cnt - 8'h1;
      st_nxt.acyc = st_r.acyc_req;
      st_nxt.acyc_req = 1'b0;
    end
    if (link.sample) begin
      st_nxt.samples = st_r.samples + 16'h1;
    end
    if (st_r.s3_pend) begin
      // mode 3 with double sampling needs cdsref cleared
      st_nxt.s3_pend = 1'b0;
      st_nxt.cfg_wr = 1'b1;
      st_nxt.cfg_addr = A_SETUP3;
      st_nxt.cfg_data = st_r.s3_base & ~(8'h3 << S3_CDSREF);
    end
    if (wr_acc && mapped) begin
      unique case (i_paddr)
        R_CTRL: st_nxt.run = i_pwdata[0];
        R_DIV: st_nxt.div = (i_pwdata[7:0] < MCLK_DIV_MIN) ? MCLK_DIV_MIN
                            : i_pwdata[7:0];
        R_MODE: begin
          st_nxt.mode = i_pwdata[2:0];
          st_nxt.cds = i_pwdata[3] & (i_pwdata[2:0] != 3'h4);
          st_nxt.slow_n = i_pwdata[14:8];
          st_nxt.s3_base = i_pwdata[23:16];
          if (i_pwdata[31]) begin
            st_nxt.cfg_wr = 1'b1;
            st_nxt.cfg_addr = A_SETUP1;
            st_nxt.cfg_data = setup1_of(i_pwdata[2:0], i_pwdata[3]);
            st_nxt.s3_pend = (i_pwdata[2:0] == 3'h3) & i_pwdata[3];
          end
        end
        // raw device write, e.g. new single_input_select between lines
        R_CFG: begin
          st_nxt.cfg_wr = 1'b1;
          st_nxt.cfg_addr = i_pwdata[13:8];
          st_nxt.cfg_data = i_pwdata[7:0];
        end
        R_ACYC: st_nxt.acyc_req = 1'b1;
        default: st_nxt = st_nxt;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st_r <= '0;
      st_r.div <= MCLK_DIV_RST;
      st_r.mode <= 3'h1;
      st_r.s3_base <= SETUP3_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    o_prdata = 32'h0;
    unique case (i_paddr)
      R_CTRL: o_prdata = {31'h0, st_r.run};
      R_DIV: o_prdata = {24'h0, st_r.div};
      R_MODE: o_prdata = {8'h0, st_r.s3_base, 1'b0, st_r.slow_n, 4'h0, st_r.cds, st_r.mode};
      R_STAT: o_prdata = {14'h0, st_r.s3_pend, st_r.acyc_req, st_r.samples};
      default: o_prdata = 32'h0;
    endcase
  end

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign link.mclk_en = tick;
  assign link.pixel_sync = st_r.sync;
  assign link.autocycle_pulse_pin = st_r.acyc;
  assign link.cfg_wr = st_r.cfg_wr;
  assign link.cfg_addr = st_r.cfg_addr;
  assign link.cfg_data = st_r.cfg_data;
endmodule

/* File: test/astcs_chk.sv */
/*
  astcs_chk: assertions on the link between timing controller and device.
  assumes: instantiated once beside the link; one clock domain.
*/
module astcs_chk
  import astcs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic mclk_en,
  input wire logic pixel_sync,
  input wire logic autocycle_pulse_pin,
  input wire logic cfg_wr,
  input wire logic [5:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  input wire logic sample
);
  timeunit 1ns;
  timeprecision 100ps;
  // shadow of the device setup written over the link
  logic [7:0] s1_r;
  logic [7:0] s5_r;
  logic [7:0] s6_r;
  logic [2:0] sync_n_r;
  logic [2:0] acyc_n_r;
  logic off;
  logic det;
  logic pos;
  assign off = s1_r[S1_SELPWR] ? (s6_r[3:0] == 4'hF) : !s1_r[S1_EN];
  assign det = s5_r[S5_DET];
  assign pos = s5_r[S5_POS];
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      s1_r <= SETUP1_RST;
      s5_r <= SETUP5_RST;
      s6_r <= SETUP6_RST;
      sync_n_r <= 3'h0;
      acyc_n_r <= 3'h0;
    end else begin
      if (cfg_wr && cfg_addr == A_SETUP1) s1_r <= cfg_data;
      if (cfg_wr && cfg_addr == A_SETUP5) s5_r <= cfg_data;
      if (cfg_wr && cfg_addr == A_SETUP6) s6_r <= cfg_data;
      sync_n_r <= !pixel_sync ? 3'h0 : sync_n_r + 3'(mclk_en);
      acyc_n_r <= !autocycle_pulse_pin ? 3'h0 : acyc_n_r + 3'(mclk_en);
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  a_sync_one_mclk: assert property ($fell(pixel_sync) |-> sync_n_r == 3'h1)
    else $error("pixel sync not one master clock wide");
  a_acyc_one_mclk: assert property ($fell(autocycle_pulse_pin) |-> acyc_n_r == 3'h1)
    else $error("cycle pulse not one master clock wide");
  a_sync_on_tick: assert property ($changed(pixel_sync) |-> $past(mclk_en))
    else $error("pixel sync moved off a master clock edge");
  a_acyc_on_tick: assert property ($rose(autocycle_pulse_pin) |-> $past(mclk_en))
    else $error("cycle pulse rose off a master clock edge");
  a_sample_on_tick: assert property (sample |-> $past(mclk_en))
    else $error("sample not on a master clock edge");
  a_sample_single: assert property (sample |=> !sample)
    else $error("sample pulse longer than one cycle");
  a_normal_sample: assert property ($fell(pixel_sync) && !det && !off
    |-> ##[1:600] (sample || det || off))
    else $error("no sample after pixel sync fell");
  a_detect_sample: assert property (det && !off && (pos ? $rose(pixel_sync) : $fell(pixel_sync))
    |-> ##[1:1000] (sample || !det || off))
    else $error("no sample after detected edge");
  a_off_quiet: assert property (off && $past(off) && $past(off, 2) |-> !sample)
    else $error("sample while powered down");
  a_mode3_setup3: assert property (cfg_wr && cfg_addr == A_SETUP3 && $past(cfg_wr)
    && $past(cfg_addr) == A_SETUP1 |-> cfg_data[5:4] == 2'h0)
    else $error("mode 3 setup3 bits 5:4 not cleared");
  a_max_speed_select_value: assert property (cfg_wr && cfg_addr == A_SETUP1 && cfg_data[S1_MAXSPD]
    |-> cfg_data == S1_M4)
    else $error("max speed setup value wrong");
  c_sample: cover property (sample && !det);
  c_detect: cover property (sample && det);
  c_cycle: cover property ($rose(autocycle_pulse_pin));
endmodule

/* File: test/astcs_test.sv */
/*
  astcs_test: controller and device joined by the link, driven over APB.
  assumes: zero or more wait state APB slave; expectations from the package.
*/
module astcs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import astcs_pkg::*;
  logic clk_sys;
  logic reset_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic err;
  logic [31:0] r;
  logic dv_sample;
  logic [2:0] dv_inputs;
  logic [3:0] block_en;
  logic [2:0] chan_en;
  logic mono;
  logic cds;
  logic max_speed;
  logic [1:0] input_sel;
  logic [1:0] coef_sel;
  logic [7:0] setup3;
  int fails = 0;
  int n_compared = 0;
  int n;
  int n0;
  // mode word, sync ratio, {max_speed,mono,cds}, inputs sampled
  logic [31:0] mw [4] = '{32'h801F_0409, 32'h801F_040B, 32'h801F_040C, 32'h801F_0405};
  logic [31:0] rt [4] = '{32'h6, 32'h3, 32'h2, 32'h8};
  logic [2:0] fl [4] = '{3'h1, 3'h3, 3'h6, 3'h0};
  logic [2:0] si [4] = '{3'h7, 3'h1, 3'h1, 3'h7};
  // bit 31 cycle pulse, else config word; [19:16] expected {input,coef}
  logic [31:0] st [10] = '{32'h0000_0603, 32'h8005_0000, 32'h800A_0000, 32'h8000_0000,
    32'h8005_0000, 32'h0009_0687, 32'h800A_0000, 32'h0008_0500, 32'h0009_0695,
    32'h0005_0611};
  logic [7:0] dt [4] = '{8'h11, 8'h17, 8'h1F, 8'h01};
  logic [31:0] dd [4] = '{32'h0, 32'h3, 32'h7, 32'h0};

  astcs_link_if link();
  astcs_ctrl u_astcs_ctrl (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link));
  astcs_device u_astcs_device (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .link(link),
    .o_sample(dv_sample), .o_sample_inputs(dv_inputs), .o_block_en(block_en),
    .o_chan_en(chan_en), .o_mono(mono), .o_cds(cds), .o_max_speed(max_speed),
    .o_input_sel(input_sel), .o_coef_sel(coef_sel), .o_setup3(setup3));
  astcs_chk u_astcs_chk (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .mclk_en(link.mclk_en),
    .pixel_sync(link.pixel_sync), .autocycle_pulse_pin(link.autocycle_pulse_pin),
    .cfg_wr(link.cfg_wr), .cfg_addr(link.cfg_addr), .cfg_data(link.cfg_data),
    .sample(link.sample));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hangs here are cut short by the watchdog only
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic [5:0] a, input logic [7:0] d);
    apb(1'b1, R_CFG, {18'h0, a, d}, r);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic ticks(input int k);
    while (k > 0) begin
      @(posedge clk_sys);
      #1;
      if (link.mclk_en === 1'b1) k--;
    end
  endtask

  // counts master clock ticks up to the chosen pixel sync edge
  task automatic wait_sync(input logic rise, output int cnt);
    logic prev;
    prev = rise;
    cnt = 0;
    forever begin
      @(posedge clk_sys);
      #1;
      if (link.mclk_en === 1'b1) cnt++;
      if (link.pixel_sync === rise && prev !== rise) break;
      prev = link.pixel_sync;
    end
  endtask

  task automatic to_sample(output int cnt);
    cnt = 0;
    forever begin
      @(posedge clk_sys);
      #1;
      if (dv_sample === 1'b1) break;
      if (link.mclk_en === 1'b1) cnt++;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    summarize();
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({block_en, chan_en, mono, cds, max_speed, setup3}, {4'hF, 3'h7, 3'h2, 8'h1F});
    // a divider below the minimum is clamped so mclk stays in range
    apb(1'b1, R_DIV, 32'h2, r);
    apb(1'b0, R_DIV, 32'h0, r);
    chk(r, {24'h0, MCLK_DIV_MIN});
    apb(1'b1, R_CTRL, 32'h1, r);
    apb(1'b0, R_CTRL, 32'h0, r);
    chk(r, 32'h1);
    apb(1'b0, 8'h18, 32'h0, r);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, R_MODE, mw[i], r);
      wait_sync(1'b1, n);
      wait_sync(1'b1, n);
      wait_sync(1'b1, n);
      chk(n, rt[i]); // sync period
      chk({max_speed, mono, cds}, fl[i]);
      to_sample(n);
      chk(dv_inputs, si[i]);
    end
    chk(setup3, 8'h0F);
    cfg(A_SETUP1, 8'h00);
    chk(block_en, 4'h0);
    ticks(20);
    cfg(A_SETUP6, 8'h05);
    cfg(A_SETUP1, 8'h08);
    chk(block_en, 4'hA);
    chk(setup3, 8'h0F);
    cfg(A_SETUP6, 8'h00);
    cfg(A_SETUP1, S1_M1_NOCDS);
    for (int i = 0; i < 10; i++) begin
      if (st[i][31]) begin
        apb(1'b1, R_ACYC, 32'h0, r);
      end else begin
        cfg(st[i][13:8], st[i][7:0]);
      end
      ticks(4);
      chk({input_sel, coef_sel}, st[i][19:16]);
      if (i == 0) chk({chan_en, mono}, 4'h3);
    end
    cfg(A_SETUP4, 8'h00);
    cfg(A_SETUP3, 8'h8F);
    chk(input_sel, 2'h2);
    // longer period so a seven tick delay still ends inside it
    apb(1'b1, R_MODE, 32'h801F_0805, r);
    for (int i = 0; i < 4; i++) begin
      cfg(A_SETUP5, dt[i]);
      for (int k = 0; k < 2; k++) begin
        wait_sync(dt[i][S5_POS], n);
        to_sample(n);
      end
      if (i == 0) n0 = n;
      chk(n, n0 + dd[i]);
    end
    summarize();
  end
endmodule
